/* File: core/fbio_params.sv */
// Parameter, status and process-image logic of the fieldbus I/O device.
// Assumes all inputs synchronous to clk; record writes arrive as single-cycle strobes.
// Overview of operation
// - Discover attached heads, build process image.
// - Slot 0 is communicator: trigger, temperature.
// - Slots 1..8 map heads in physical order.
// - Record writes applied before cyclic exchange.
// - Signal readiness, then send cyclic data.
// - Each module has a diagnostics enable.
// - Periphery diagnostics setting gates all reports.
// - Module fault: zero or hold process data.
// - Head setting overrides communicator default.
// - Celsius or Fahrenheit temperature unit select.
// - Reduced variant: only unit and head settings are adjustable.
// - Output scaling endpoints within 0..3000.
// - Output source: head number, internal/object.
// - Output one: J,K,R,S,5V,10V,off.
// - Output two: 20mA,4-20mA,5V,10V,off.
// - LEDs: off, yellow+blink, both on.
// - Communicator input: five bytes, big-endian.
// - Head input: eight bytes, object then internal.
`timescale 1ns/10ps
`default_nettype none
module fbio_params #(
  parameter int unsigned BLINK_HALF_CYC = fbio_pkg::BLINK_HALF_CYC
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic link_up,
  input wire logic din_variant,
  input wire logic [7:0] head_present,
  input wire logic rec_wr,
  input wire logic [3:0] rec_slot,
  input wire logic [3:0] rec_idx,
  input wire logic [15:0] rec_data,
  input wire logic rec_done,
  input wire logic trigger_in,
  input wire logic [31:0] comm_temp,
  input wire logic [7:0][31:0] head_obj_temp,
  input wire logic [7:0][31:0] head_int_temp,
  input wire logic [7:0] head_fault,
  input wire logic comm_diag,
  input wire logic [7:0] head_diag,
  output logic ready_q,
  output logic exchange_q,
  output logic led_yellow_q,
  output logic led_green_q,
  output logic [7:0] slot_valid_q,
  output logic [39:0] pi_comm_q,
  output logic [7:0][63:0] pi_head_q,
  output logic [8:0] diag_out_q,
  output logic unit_q,
  output logic [7:0] slot_unit_q,
  output logic [2:0] ao1_mode_q,
  output logic [2:0] ao2_mode_q,
  output logic [1:0][11:0] ao_bot_q,
  output logic [1:0][11:0] ao_top_q,
  output logic [1:0][3:0] ao_head_q,
  output logic [1:0] ao_type_q,
  output logic [1:0][31:0] ao_value_q
);
  fbio_pkg::fbio_state_t state_q;
  logic din_q;
  logic periph_q;
  logic fault_mode_q;
  logic [8:0] diag_en_q;
  logic [7:0] unit_ovr_q;
  logic [7:0] unit_val_q;
  logic [7:0][2:0] slot_src_q;
  logic [7:0][2:0] src_d;
  logic [7:0] valid_d;
  logic [3:0] cnt;
  logic [fbio_pkg::BLINK_W-1:0] blink_cnt_q;
  logic blink_q;
  logic wr_comm;
  logic wr_cfg;
  logic rng_ok;
  logic head_ok;

  // Writes only count while parameters are awaited, so every setting is settled
  // before the first cyclic frame leaves.
  assign wr_cfg = rec_wr && (state_q == fbio_pkg::ST_PARAM);
  assign wr_comm = wr_cfg && (rec_slot == fbio_pkg::SLOT_COMM);
  assign rng_ok = (rec_data <= fbio_pkg::TEMP_MAX);
  assign head_ok = (rec_data[3:0] >= fbio_pkg::HEAD_NUM_MIN) &&
                   (rec_data[3:0] <= fbio_pkg::HEAD_NUM_MAX) && (rec_data[15:4] == 12'h000);

  always_ff @(posedge clk)
  begin
    if (reset || !link_up)
      state_q <= fbio_pkg::ST_OFF;
    else
    begin
      case (state_q)
        fbio_pkg::ST_OFF: state_q <= fbio_pkg::ST_INIT;
        fbio_pkg::ST_INIT: state_q <= fbio_pkg::ST_PARAM;
        fbio_pkg::ST_PARAM: if (rec_done) state_q <= fbio_pkg::ST_DATA;
        fbio_pkg::ST_DATA: state_q <= fbio_pkg::ST_DATA;
        default: state_q <= fbio_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    ready_q <= !reset && link_up && (state_q == fbio_pkg::ST_PARAM) && rec_done;
    exchange_q <= !reset && link_up && (state_q == fbio_pkg::ST_DATA);
  end

  // Packs the attached heads into consecutive slots in physical order.
  always_comb
  begin
    cnt = 4'h0;
    src_d = '0;
    valid_d = '0;
    for (int h = 0; h < fbio_pkg::NHEAD; h++)
    begin
      if (head_present[h])
      begin
        src_d[cnt[2:0]] = 3'(h);
        valid_d[cnt[2:0]] = 1'b1;
        cnt = cnt + 4'h1;
      end
    end
  end

  // The strap is caught by the clock at discovery, never by the reset.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      slot_valid_q <= '0;
      slot_src_q <= '0;
      din_q <= 1'b0;
    end
    else if (state_q == fbio_pkg::ST_INIT)
    begin
      slot_valid_q <= valid_d;
      slot_src_q <= src_d;
      din_q <= din_variant;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      unit_q <= fbio_pkg::UNIT_C;
      periph_q <= 1'b0;
      fault_mode_q <= fbio_pkg::FAULT_ZERO;
    end
    else if (wr_comm && rec_idx == fbio_pkg::RI_UNIT)
      unit_q <= rec_data[0];
    else if (wr_comm && !din_q && rec_idx == fbio_pkg::RI_PERIPH)
      periph_q <= rec_data[0];
    else if (wr_comm && !din_q && rec_idx == fbio_pkg::RI_FAULT)
      fault_mode_q <= rec_data[0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ao1_mode_q <= fbio_pkg::AO1_OFF;
      ao2_mode_q <= fbio_pkg::AO2_OFF;
    end
    else if (state_q == fbio_pkg::ST_INIT && din_variant)
    begin
      ao1_mode_q <= fbio_pkg::AO1_OFF;
      ao2_mode_q <= fbio_pkg::AO2_OFF;
    end
    else if (wr_comm && !din_q)
    begin
      if (rec_idx == fbio_pkg::RI_AO1_MODE && rec_data <= 16'(fbio_pkg::AO1_OFF))
        ao1_mode_q <= rec_data[2:0];
      if (rec_idx == fbio_pkg::RI_AO2_MODE && rec_data <= 16'(fbio_pkg::AO2_OFF))
        ao2_mode_q <= rec_data[2:0];
    end
  end

  // Per-output scaling and source settings; out-of-range values are dropped.
  for (genvar i = 0; i < 2; i++)
  begin : g_ao
    localparam logic [3:0] IB = i ? fbio_pkg::RI_AO2_BOT : fbio_pkg::RI_AO1_BOT;
    localparam logic [3:0] IT = i ? fbio_pkg::RI_AO2_TOP : fbio_pkg::RI_AO1_TOP;
    localparam logic [3:0] IH = i ? fbio_pkg::RI_AO2_HEAD : fbio_pkg::RI_AO1_HEAD;
    localparam logic [3:0] IY = i ? fbio_pkg::RI_AO2_TYPE : fbio_pkg::RI_AO1_TYPE;
    logic [2:0] hx;
    assign hx = 3'(ao_head_q[i] - fbio_pkg::HEAD_NUM_MIN);
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        ao_bot_q[i] <= fbio_pkg::TEMP_BOT_RST;
        ao_top_q[i] <= fbio_pkg::TEMP_TOP_RST;
        ao_head_q[i] <= fbio_pkg::HEAD_NUM_MIN;
        ao_type_q[i] <= fbio_pkg::SRC_OBJ;
      end
      else if (wr_comm && !din_q)
      begin
        if (rec_idx == IB && rng_ok)
          ao_bot_q[i] <= rec_data[11:0];
        if (rec_idx == IT && rng_ok)
          ao_top_q[i] <= rec_data[11:0];
        if (rec_idx == IH && head_ok)
          ao_head_q[i] <= rec_data[3:0];
        if (rec_idx == IY)
          ao_type_q[i] <= rec_data[0];
      end
    end
    always_ff @(posedge clk)
    begin
      if (reset)
        ao_value_q[i] <= '0;
      else if (!slot_valid_q[hx])
        ao_value_q[i] <= '0;
      else if (ao_type_q[i] == fbio_pkg::SRC_OBJ)
        ao_value_q[i] <= pi_head_q[hx][63:32];
      else
        ao_value_q[i] <= pi_head_q[hx][31:0];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      diag_en_q <= '0;
    else if (wr_cfg && rec_idx == fbio_pkg::RI_DIAG_EN && rec_slot <= fbio_pkg::SLOT_LAST)
      if (rec_slot != fbio_pkg::SLOT_COMM || !din_q)
        diag_en_q[rec_slot] <= rec_data[0];
  end

  always_ff @(posedge clk)
  begin
    if (reset || state_q != fbio_pkg::ST_DATA)
      pi_comm_q <= '0;
    else
      pi_comm_q <= {7'h00, trigger_in, comm_temp};
    diag_out_q[0] <= !reset && periph_q && diag_en_q[0] && comm_diag;
  end

  // One slot per attached head: process data, fault reaction, unit and diagnostics.
  for (genvar s = 0; s < fbio_pkg::NHEAD; s++)
  begin : g_slot
    logic [2:0] h;
    assign h = slot_src_q[s];
    always_ff @(posedge clk)
    begin
      if (reset)
        pi_head_q[s] <= '0;
      else if (state_q != fbio_pkg::ST_DATA || !slot_valid_q[s])
        pi_head_q[s] <= '0;
      else if (head_fault[h])
      begin
        if (fault_mode_q == fbio_pkg::FAULT_ZERO)
          pi_head_q[s] <= '0;
      end
      else
        pi_head_q[s] <= {head_obj_temp[h], head_int_temp[h]};
    end
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        unit_ovr_q[s] <= 1'b0;
        unit_val_q[s] <= fbio_pkg::UNIT_C;
      end
      else if (wr_cfg && rec_slot == 4'(s + 1) && rec_idx == fbio_pkg::RI_HEAD_UNIT)
      begin
        unit_ovr_q[s] <= rec_data[1];
        unit_val_q[s] <= rec_data[0];
      end
    end
    always_ff @(posedge clk)
    begin
      if (reset)
      begin
        slot_unit_q[s] <= fbio_pkg::UNIT_C;
        diag_out_q[s + 1] <= 1'b0;
      end
      else
      begin
        slot_unit_q[s] <= unit_ovr_q[s] ? unit_val_q[s] : unit_q;
        diag_out_q[s + 1] <= periph_q && diag_en_q[s + 1] && slot_valid_q[s] &&
                             head_diag[h];
      end
    end
  end

  // Blink counter runs only while configuration is awaited; each phase has the same length.
  always_ff @(posedge clk)
  begin
    if (reset || state_q == fbio_pkg::ST_OFF || state_q == fbio_pkg::ST_DATA)
    begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end
    else if (blink_cnt_q == fbio_pkg::BLINK_W'(BLINK_HALF_CYC - 1))
    begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end
    else
      blink_cnt_q <= blink_cnt_q + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      led_yellow_q <= 1'b0;
      led_green_q <= 1'b0;
    end
    else
    begin
      led_yellow_q <= (state_q != fbio_pkg::ST_OFF);
      led_green_q <= (state_q == fbio_pkg::ST_DATA) || blink_q;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  sequence s_param_done;
    link_up && state_q == fbio_pkg::ST_PARAM && rec_done;
  endsequence
  sequence s_in_data;
    link_up && state_q == fbio_pkg::ST_DATA ##1 link_up;
  endsequence

  a_ready_then_data: assert property (s_param_done |=> ready_q ##1 exchange_q)
    else $error("Readiness not followed by data exchange.");
  a_no_early_data: assert property (state_q == fbio_pkg::ST_PARAM |->
    pi_comm_q == '0 && pi_head_q == '0)
    else $error("Process data sent before readiness.");
  a_discover_count: assert property (state_q == fbio_pkg::ST_INIT |=>
    $countones(slot_valid_q) == $countones($past(head_present)))
    else $error("Discovered head count wrong.");
  a_periph_gate: assert property (!periph_q |=> diag_out_q == '0)
    else $error("Diagnostics leaked while periphery setting inactive.");
  a_comm_diag_fwd: assert property (periph_q && diag_en_q[0] && comm_diag |=>
    diag_out_q[0])
    else $error("Communicator diagnostics not forwarded.");
  a_fault_zero: assert property (state_q == fbio_pkg::ST_DATA &&
    fault_mode_q == fbio_pkg::FAULT_ZERO && head_fault[slot_src_q[0]] |=> pi_head_q[0] == '0)
    else $error("Faulted slot not cleared.");
  a_fault_hold: assert property (state_q == fbio_pkg::ST_DATA &&
    fault_mode_q == fbio_pkg::FAULT_HOLD && head_fault[slot_src_q[0]] |=> $stable(pi_head_q[0]))
    else $error("Faulted slot not held.");
  a_range_drop: assert property (wr_comm && rec_idx == fbio_pkg::RI_AO1_TOP && !rng_ok
    |=> $stable(ao_top_q[0]))
    else $error("Out-of-range endpoint accepted.");
  a_din_lock: assert property (din_q && state_q != fbio_pkg::ST_OFF |->
    ao1_mode_q == fbio_pkg::AO1_OFF && ao2_mode_q == fbio_pkg::AO2_OFF)
    else $error("Analog output active in reduced variant.");
  a_led_data: assert property (s_in_data |=> led_yellow_q && led_green_q)
    else $error("LEDs not both on in data exchange.");
  a_unit_ovr: assert property (!unit_ovr_q[0] |=> slot_unit_q[0] == $past(unit_q))
    else $error("Head unit does not follow the default.");
endmodule : fbio_params
`default_nettype wire

/* File: core/fbio_pkg.sv */
// Constants for the fieldbus I/O device parameter and process-image block.
// Assumes a 100 MHz system clock and up to eight sensing heads.
package fbio_pkg;
  localparam int unsigned NHEAD = 8;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned BLINK_HZ = 1;
  // Half of the blink period gives equal on and off phases.
  localparam int unsigned BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
  localparam int unsigned BLINK_W = 26;
  localparam logic [3:0] SLOT_COMM = 4'h0;
  localparam logic [3:0] SLOT_LAST = 4'h8;
  // Record indices of the communicator slot.
  localparam logic [3:0] RI_UNIT = 4'h0;
  localparam logic [3:0] RI_PERIPH = 4'h1;
  localparam logic [3:0] RI_FAULT = 4'h2;
  localparam logic [3:0] RI_DIAG_EN = 4'h3;
  localparam logic [3:0] RI_AO1_BOT = 4'h4;
  localparam logic [3:0] RI_AO1_TOP = 4'h5;
  localparam logic [3:0] RI_AO2_BOT = 4'h6;
  localparam logic [3:0] RI_AO2_TOP = 4'h7;
  localparam logic [3:0] RI_AO1_HEAD = 4'h8;
  localparam logic [3:0] RI_AO1_TYPE = 4'h9;
  localparam logic [3:0] RI_AO1_MODE = 4'hA;
  localparam logic [3:0] RI_AO2_HEAD = 4'hB;
  localparam logic [3:0] RI_AO2_TYPE = 4'hC;
  localparam logic [3:0] RI_AO2_MODE = 4'hD;
  // Record indices of a head slot; RI_DIAG_EN is shared.
  localparam logic [3:0] RI_HEAD_UNIT = 4'h1;
  localparam logic [15:0] TEMP_MAX = 16'h0BB8;
  localparam logic [11:0] TEMP_BOT_RST = 12'h000;
  localparam logic [11:0] TEMP_TOP_RST = 12'hBB8;
  localparam logic [3:0] HEAD_NUM_MIN = 4'h1;
  localparam logic [3:0] HEAD_NUM_MAX = 4'h8;
  localparam logic SRC_INT = 1'b0;
  localparam logic SRC_OBJ = 1'b1;
  localparam logic UNIT_C = 1'b0;
  localparam logic UNIT_F = 1'b1;
  localparam logic FAULT_ZERO = 1'b0;
  localparam logic FAULT_HOLD = 1'b1;
  // Output one modes.
  localparam logic [2:0] AO1_TCJ = 3'h0;
  localparam logic [2:0] AO1_TCK = 3'h1;
  localparam logic [2:0] AO1_TCR = 3'h2;
  localparam logic [2:0] AO1_TCS = 3'h3;
  localparam logic [2:0] AO1_V5 = 3'h4;
  localparam logic [2:0] AO1_V10 = 3'h5;
  localparam logic [2:0] AO1_OFF = 3'h6;
  // Output two modes.
  localparam logic [2:0] AO2_MA20 = 3'h0;
  localparam logic [2:0] AO2_MA420 = 3'h1;
  localparam logic [2:0] AO2_V5 = 3'h2;
  localparam logic [2:0] AO2_V10 = 3'h3;
  localparam logic [2:0] AO2_OFF = 3'h4;
  typedef enum logic [3:0] {
    ST_OFF = 4'b0001,
    ST_INIT = 4'b0010,
    ST_PARAM = 4'b0100,
    ST_DATA = 4'b1000
  } fbio_state_t;
endpackage : fbio_pkg

/* File: dv/fbio_ctrl_model.sv */
// Model of the I/O controller: link state, record writes and end of parameterisation.
// Assumes its tasks are called from one bench process, just after a rising clk edge.
`timescale 1ns/10ps
`default_nettype none
module fbio_ctrl_model (
  input wire logic clk,
  output logic link_up,
  output logic rec_wr,
  output logic [3:0] rec_slot,
  output logic [3:0] rec_idx,
  output logic [15:0] rec_data,
  output logic rec_done
);
  initial
  begin
    link_up = 1'b0;
    rec_wr = 1'b0;
    rec_slot = 4'hF;
    rec_idx = 4'hF;
    rec_data = 16'hFFFF;
    rec_done = 1'b0;
  end

  // Waits until the device has reached the parameter state, or the off state when the link drops.
  task automatic link(input logic on);
    link_up = on;
    repeat (3) @(posedge clk);
    #1;
  endtask : link

  // Heads are addressed by slot, so no head number is ever sent twice.
  task automatic wr(input logic [3:0] s, input logic [3:0] i, input logic [15:0] d);
    rec_slot = s;
    rec_idx = i;
    rec_data = d;
    rec_wr = 1'b1;
    @(posedge clk);
    #1;
    rec_wr = 1'b0;
    // The data lines are inverted so a stale value cannot pass for a new write.
    rec_data = ~d;
    repeat (2) @(posedge clk);
    #1;
  endtask : wr

  task automatic done();
    rec_done = 1'b1;
    @(posedge clk);
    #1;
    rec_done = 1'b0;
  endtask : done
endmodule : fbio_ctrl_model
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the parameter and process-image block.
// Assumes the controller model drives link_up and the record inputs; the bench drives the rest.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk, reset, link_up, din_variant, rec_wr, rec_done, trigger_in, comm_diag;
  logic [7:0] head_present, head_fault, head_diag, slot_valid_q, slot_unit_q;
  logic [3:0] rec_slot, rec_idx;
  logic [15:0] rec_data;
  logic [31:0] comm_temp;
  logic [7:0][31:0] head_obj_temp, head_int_temp;
  logic ready_q, exchange_q, led_yellow_q, led_green_q, unit_q, g;
  logic [39:0] pi_comm_q;
  logic [7:0][63:0] pi_head_q;
  logic [8:0] diag_out_q;
  logic [2:0] ao1_mode_q, ao2_mode_q;
  logic [1:0][11:0] ao_bot_q, ao_top_q;
  logic [1:0][3:0] ao_head_q;
  logic [1:0] ao_type_q;
  logic [1:0][31:0] ao_value_q;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;

  fbio_params #(.BLINK_HALF_CYC(4)) u_dut (.clk, .reset, .link_up, .din_variant,
    .head_present, .rec_wr, .rec_slot, .rec_idx, .rec_data, .rec_done, .trigger_in,
    .comm_temp, .head_obj_temp, .head_int_temp, .head_fault, .comm_diag, .head_diag,
    .ready_q, .exchange_q, .led_yellow_q, .led_green_q, .slot_valid_q, .pi_comm_q,
    .pi_head_q, .diag_out_q, .unit_q, .slot_unit_q, .ao1_mode_q, .ao2_mode_q, .ao_bot_q,
    .ao_top_q, .ao_head_q, .ao_type_q, .ao_value_q);
  fbio_ctrl_model u_ctrl (.clk, .link_up, .rec_wr, .rec_slot, .rec_idx, .rec_data, .rec_done);

  always #5 clk = ~clk;

  task automatic end_of_test();
    if (err_total == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  // The whole run needs well under 1500 cycles.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
    tests_run++;
    if (e !== s)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic go_data();
    int n;
    n = 0;
    u_ctrl.done();
    while (ready_q !== 1'b1 && n < 4)
    begin
      tick(1);
      n++;
    end
    chk("ready_q", 64'h1, ready_q);
    tick(1);
    chk("ready_pulse", 64'h0, ready_q);
    tick(2);
    chk("exchange_q", 64'h1, exchange_q);
    chk("leds_data", 64'h3, {led_yellow_q, led_green_q});
  endtask : go_data

  initial
  begin
    clk = 1'b0;
    reset = 1'b1;
    din_variant = 1'b1;
    head_present = 8'h05;
    trigger_in = 1'b1;
    comm_temp = 32'h41C8_0000;
    comm_diag = 1'b1;
    head_diag = 8'hFF;
    head_fault = 8'h00;
    for (int h = 0; h < 8; h++)
    begin
      head_obj_temp[h] = 32'h4100_0000 + 32'(h);
      head_int_temp[h] = 32'h4200_0000 + 32'(h);
    end
    tick(16);
    reset = 1'b0;
    chk("ao_modes", 64'h34, {ao1_mode_q, ao2_mode_q});
    chk("ao_top", 64'hBB8BB8, ao_top_q);
    chk("leds_off", 64'h0, {led_yellow_q, led_green_q});
    // Reduced variant: only the unit and head settings may change, periphery stays inactive.
    u_ctrl.link(1'b1);
    g = led_green_q;
    chk("led_yellow", 64'h1, led_yellow_q);
    tick(4);
    chk("led_blink", 64'(!g), led_green_q);
    chk("pi_idle", 64'h0, pi_comm_q);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_UNIT, 16'h0001);
    chk("unit_q", 64'h1, unit_q);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO1_BOT, 16'h0064);
    chk("ao_bot_reduced", 64'h0, ao_bot_q);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_PERIPH, 16'h0001);
    go_data();
    tick(2);
    chk("pi_comm", {24'h0, 7'h00, trigger_in, comm_temp}, pi_comm_q);
    chk("slot_valid", 64'h03, slot_valid_q);
    chk("slot2_map", {head_obj_temp[2], head_int_temp[2]}, pi_head_q[1]);
    chk("diag_off", 64'h0, diag_out_q);
    head_fault = 8'h05;
    tick(2);
    chk("fault_zero", 64'h0, pi_head_q[1]);
    chk("fault_zero0", 64'h0, pi_head_q[0]);
    head_fault = 8'h00;
    u_ctrl.link(1'b0);
    chk("leds_down", 64'h0, {exchange_q, led_yellow_q, led_green_q});
    // Full variant: periphery active, hold on fault, full parameter set.
    din_variant = 1'b0;
    head_diag = 8'h05;
    u_ctrl.link(1'b1);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_PERIPH, 16'h0001);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_FAULT, 16'h0001);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_DIAG_EN, 16'h0001);
    u_ctrl.wr(4'h1, fbio_pkg::RI_DIAG_EN, 16'h0001);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_UNIT, 16'h0000);
    u_ctrl.wr(4'h1, fbio_pkg::RI_HEAD_UNIT, 16'h0003);
    tick(1);
    chk("slot_unit", 64'h01, slot_unit_q);
    for (int k = 0; k < 4; k++)
    begin
      u_ctrl.wr(fbio_pkg::SLOT_COMM, 4'(4 + k), 16'(500 * (k + 1)));
      chk("ao_scale", 64'(500 * (k + 1)), k[0] ? ao_top_q[k / 2] : ao_bot_q[k / 2]);
    end
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO1_TOP, fbio_pkg::TEMP_MAX);
    chk("ao1_top_max", 64'hBB8, ao_top_q[0]);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO1_TOP, 16'h0BB9);
    chk("ao1_top_over", 64'hBB8, ao_top_q[0]);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO2_BOT, 16'h0BB9);
    chk("ao2_bot_over", 64'h5DC, ao_bot_q[1]);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO2_HEAD, 16'h0008);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO2_HEAD, 16'h0009);
    chk("ao2_head", 64'h8, ao_head_q[1]);
    u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO1_TYPE, 16'h0000);
    chk("ao1_type", 64'h0, ao_type_q[0]);
    for (int m = 0; m < 8; m++)
    begin
      u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO1_MODE, 16'(m));
      chk("ao1_mode", (m > 6) ? 64'(fbio_pkg::AO1_OFF) : 64'(m), ao1_mode_q);
    end
    for (int m = 0; m < 6; m++)
    begin
      u_ctrl.wr(fbio_pkg::SLOT_COMM, fbio_pkg::RI_AO2_MODE, 16'(m));
      chk("ao2_mode", (m > 4) ? 64'(fbio_pkg::AO2_OFF) : 64'(m), ao2_mode_q);
    end
    go_data();
    tick(2);
    chk("diag_on", 64'h003, diag_out_q);
    chk("ao_value", {32'h0, head_int_temp[0]}, ao_value_q);
    head_obj_temp[2] = 32'h4300_0000;
    tick(2);
    chk("pi_live", {head_obj_temp[2], head_int_temp[2]}, pi_head_q[1]);
    head_fault = 8'h01;
    tick(1);
    head_obj_temp[0] = 32'h4400_0000;
    tick(2);
    chk("fault_hold", {32'h4100_0000, head_int_temp[0]}, pi_head_q[0]);
    end_of_test();
  end
endmodule : tb
`default_nettype wire
